// *** bench/cfag_gate_checker.sv ***
// Concurrent checks on the ports of the fuse access gate
`timescale 1ns/1ps
module cfag_gate_checker (
    input logic ref_clk, // System clock
    input logic rst, // Asynchronous reset, active high
    input logic cmd_valid, // Command present
    input logic cmd_write, // Write or read
    input logic [7:0] cmd_command_parameter, // Parameter byte
    input logic [7:0] cmd_addr, // Address byte
    input logic [7:0] cmd_len, // Length byte
    input logic cmd_ready, // Gate accepts a command
    input logic fuse_prog, // Burn request
    input logic [3:0] fuse_prog_mask, // Fuse to burn
    input logic fuse_prog_done, // Burn finished
    input logic cfg_go, // Granted access pulse
    input logic cfg_go_write, // Direction of granted access
    input logic [7:0] cfg_go_addr, // Start of granted access
    input logic [7:0] cfg_go_len, // Length of granted access
    input logic rsp_valid, // Response pulse
    input logic rsp_ack, // Acknowledge flag
    input logic rsp_has_data, // Response carries data
    input logic [7:0] rsp_data, // Response data byte
    input logic [7:0] rsp_status, // Response status byte
    input logic [7:0] security_fuse_byte, // Current fuse byte
    input logic cfg_locked // Configuration locked
);
    wire take = cmd_valid && cmd_ready;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Fuse state and fuse byte layout
    a_fuse_one_time: assert property ((security_fuse_byte[3:0] & ~$past(security_fuse_byte[3:0])) == 4'h0)
        else $error("Burnt fuse came back unburnt");
    a_factory_fuse_set: assert property (security_fuse_byte[3] == 1'b0)
        else $error("Factory lock fuse not burnt");
    a_rsvd_bits_high: assert property (security_fuse_byte[7:4] == 4'hf)
        else $error("Reserved fuse bits not high");
    a_lock_follows_fuse: assert property (cfg_locked == !security_fuse_byte[0])
        else $error("Lock flag disagrees with fuse byte");
    // Fuse read answer
    a_fuse_read_answer: assert property (take && !cmd_write && cmd_command_parameter == 8'h01 && cmd_addr == 8'hff
        && cmd_len == 8'h00 |=> rsp_valid && rsp_ack && rsp_has_data && rsp_data == $past(security_fuse_byte))
        else $error("Fuse read answer wrong");
    // Burn order and acknowledge
    a_burn_in_order: assert property (fuse_prog |-> (fuse_prog_mask == 4'h4 && security_fuse_byte[2:0] == 3'h7)
        || (fuse_prog_mask == 4'h2 && security_fuse_byte[2:0] == 3'h3)
        || (fuse_prog_mask == 4'h1 && security_fuse_byte[2:0] == 3'h1))
        else $error("Fuse burnt out of order");
    a_burn_ack_status: assert property (fuse_prog && fuse_prog_done |=> !fuse_prog && rsp_valid && rsp_ack
        && rsp_status == security_fuse_byte)
        else $error("Burn answer wrong");
    a_fuse_write_no_go: assert property (take && cmd_write && cmd_command_parameter == 8'h01 |=> !cfg_go)
        else $error("Fuse write passed to memory");
    // Anticollision writes closed after first fuse
    a_anti_write_closed: assert property (take && cmd_write && cmd_command_parameter == 8'h00 && cmd_addr <= 8'h09
        && cmd_len == 8'h00 && !security_fuse_byte[2] |=> rsp_valid && !rsp_ack && !cfg_go)
        else $error("Anticollision write granted after first fuse");
    // Granted access carries the command that was taken
    a_grant_carries_cmd: assert property (cfg_go |-> rsp_valid && rsp_ack && $past(take)
        && cfg_go_addr == $past(cmd_addr) && cfg_go_len == $past(cmd_len) && cfg_go_write == $past(cmd_write))
        else $error("Granted access differs from command");
    c_burn: cover property (fuse_prog && fuse_prog_done);
    c_grant: cover property (cfg_go);
    c_error: cover property (rsp_valid && !rsp_ack);
endmodule // cfag_gate_checker

bind cfag_gate cfag_gate_checker chk_u (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_command_parameter(cmd_command_parameter), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready), .fuse_prog(fuse_prog),
    .fuse_prog_mask(fuse_prog_mask), .fuse_prog_done(fuse_prog_done), .cfg_go(cfg_go), .cfg_go_write(cfg_go_write),
    .cfg_go_addr(cfg_go_addr), .cfg_go_len(cfg_go_len), .rsp_valid(rsp_valid),
    .rsp_ack(rsp_ack), .rsp_has_data(rsp_has_data), .rsp_data(rsp_data), .rsp_status(rsp_status),
    .security_fuse_byte(security_fuse_byte), .cfg_locked(cfg_locked));

// *** bench/cfag_gate_test.sv ***
// Self-checking bench for the configuration fuse access gate
`timescale 1ns/1ps
module cfag_gate_test;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg tpw_ok = 1'b0;
    reg wpw_ok = 1'b0;
    reg [2:0] wpw_set = 3'h0;
    reg [3:0] fuse_nv = 4'h7;
    reg fuse_prog_done = 1'b0;
    reg [2:0] burn_cnt = 3'h0;
    integer error_cnt = 0;
    integer compares = 0;
    wire cmd_valid, cmd_write, cmd_ready, fuse_prog, cfg_go, rsp_valid, rsp_ack, rsp_has_data, cfg_locked;
    wire [7:0] cmd_command_parameter, cmd_addr, cmd_len, cmd_data, rsp_data, rsp_status, security_fuse_byte;
    wire [3:0] fuse_prog_mask;
    wire cfg_go_write;
    wire [7:0] cfg_go_addr, cfg_go_len;
    cfag_gate dut_u (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_command_parameter(cmd_command_parameter), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .tpw_ok(tpw_ok), .wpw_ok(wpw_ok), .wpw_set(wpw_set), .fuse_nv(fuse_nv), .fuse_prog(fuse_prog),
        .fuse_prog_mask(fuse_prog_mask), .fuse_prog_done(fuse_prog_done), .cfg_go(cfg_go),
        .cfg_go_write(cfg_go_write), .cfg_go_addr(cfg_go_addr), .cfg_go_len(cfg_go_len), .rsp_valid(rsp_valid),
        .rsp_ack(rsp_ack), .rsp_has_data(rsp_has_data),
        .rsp_data(rsp_data), .rsp_status(rsp_status), .security_fuse_byte(security_fuse_byte),
        .cfg_locked(cfg_locked));
    cfag_reader_model rd (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
        .rsp_data(rsp_data), .rsp_status(rsp_status), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_command_parameter(cmd_command_parameter), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_data(cmd_data));
    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;
    // Fuse storage: slow burn, burnt fuses survive a reset
    always @(negedge ref_clk) begin
        burn_cnt <= fuse_prog ? burn_cnt + 3'h1 : 3'h0;
        fuse_prog_done <= fuse_prog && burn_cnt == 3'h3;
        if (fuse_prog && burn_cnt == 3'h3)
            fuse_nv <= fuse_nv & ~fuse_prog_mask;
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Send a command and judge its acknowledge
    task cmd(input w, input [7:0] p, input [7:0] a, input [7:0] l, input [7:0] d, input exp_ack);
        begin
            rd.send(w, p, a, l, d);
            check({7'h0, rd.got_ack}, {7'h0, exp_ack});
        end
    endtask
    // Default fuse state, open and password gated writes, refused burns
    task t_default;
        begin
            cmd(1'b0, 8'h01, 8'hff, 8'h00, 8'h00, 1'b1); // Fuse read
            check(rd.got_data, 8'hf7); // Default fuse byte
            check({7'h0, rsp_has_data}, 8'h01); // One data byte
            cmd(1'b1, 8'h00, 8'h0a, 8'h01, 8'h5a, 1'b1); // Test zone open
            check({cfg_go, cfg_go_write, rsp_has_data, 5'h0}, 8'hc0); // Access passed, no data
            check(cfg_go_addr, 8'h0a); // Start of passed access
            check(cfg_go_len, 8'h01); // Length of passed access
            cmd(1'b1, 8'h00, 8'h00, 8'h00, 8'h11, 1'b0); // No password yet
            check({7'h0, cfg_go}, 8'h00); // Refused access not passed
            tpw_ok = 1'b1;
            cmd(1'b1, 8'h00, 8'h00, 8'h00, 8'h11, 1'b1); // Anticollision with password
            cmd(1'b1, 8'h01, 8'h04, 8'h00, 8'h00, 1'b0); // Second fuse first
            cmd(1'b1, 8'h01, 8'h06, 8'h00, 8'h01, 1'b0); // Bad burn data
            check(security_fuse_byte, 8'hf7); // Nothing burnt
        end
    endtask
    // Burn sequence and the columns it selects
    task t_burn;
        begin
            cmd(1'b1, 8'h01, 8'h06, 8'h00, 8'h00, 1'b1); // Encryption fuse
            check(rd.got_status, 8'hf3); // Status after burn
            cmd(1'b1, 8'h00, 8'h00, 8'h00, 8'h11, 1'b0); // Anticollision closed
            cmd(1'b1, 8'h00, 8'h50, 8'h00, 8'h11, 1'b1); // Cryptography still writable
            cmd(1'b1, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0); // Last fuse too early
            cmd(1'b1, 8'h01, 8'h04, 8'h00, 8'h00, 1'b1); // Secret key fuse
            check(rd.got_status, 8'hf1); // Status after burn
            cmd(1'b1, 8'h01, 8'h00, 8'h00, 8'h00, 1'b1); // Personalization fuse
            check(rd.got_status, 8'hf0); // Status after burn
            check({7'h0, cfg_locked}, 8'h01); // Configuration locked
            cmd(1'b1, 8'h00, 8'h50, 8'h00, 8'h11, 1'b0); // Cryptography closed
            cmd(1'b1, 8'h01, 8'h06, 8'h00, 8'h00, 1'b0); // Repeat burn refused
        end
    endtask
    // Locked password set needs its own write password
    task t_set_pw;
        begin
            tpw_ok = 1'b0;
            wpw_ok = 1'b1;
            cmd(1'b1, 8'h00, 8'hb0, 8'h00, 8'h03, 1'b1); // Own set counter
            wpw_set = 3'h1;
            cmd(1'b1, 8'h00, 8'hb0, 8'h00, 8'h03, 1'b0); // Other set
            wpw_ok = 1'b0;
        end
    endtask
    // Burnt fuses stay burnt through a reset
    task t_persist;
        begin
            rst = 1'b1;
            repeat (2) @(negedge ref_clk);
            rst = 1'b0;
            repeat (2) @(negedge ref_clk);
            cmd(1'b0, 8'h01, 8'hff, 8'h00, 8'h00, 1'b1); // Read after reset
            check(rd.got_data, 8'hf0); // Fuses kept
        end
    endtask
    task end_of_test;
        begin
            $display("Errors %0d, comparisons %0d", error_cnt, compares);
            if (error_cnt == 0 && compares > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    // Watchdog against a hung handshake
    initial begin
        #250000;
        error_cnt = error_cnt + 1;
        end_of_test;
    end
    // Main sequence
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        t_default;
        t_burn;
        t_set_pw;
        t_persist;
        end_of_test;
    end
endmodule // cfag_gate_test

// *** bench/cfag_reader_model.sv ***
// Reader model that issues system zone commands and collects answers
`timescale 1ns/1ps
module cfag_reader_model (
    input wire ref_clk, // System clock
    input wire cmd_ready, // Gate accepts a command
    input wire rsp_valid, // Response pulse
    input wire rsp_ack, // Acknowledge flag
    input wire [7:0] rsp_data, // Response data byte
    input wire [7:0] rsp_status, // Response status byte
    output reg cmd_valid, // Command present
    output reg cmd_write, // Write or read
    output reg [7:0] cmd_command_parameter, // Parameter byte
    output reg [7:0] cmd_addr, // Address byte
    output reg [7:0] cmd_len, // Length byte
    output reg [7:0] cmd_data // Data byte
);
    reg got_ack;
    reg [7:0] got_data;
    reg [7:0] got_status;
    integer n;
    // Idle lines at start
    initial begin
        {cmd_valid, cmd_write, cmd_command_parameter, cmd_addr, cmd_len, cmd_data} = 34'h0;
    end
    // Hold one command until taken, release the lines, then catch the answer
    task send(input w, input [7:0] p, input [7:0] a, input [7:0] l, input [7:0] d);
        begin
            @(negedge ref_clk);
            cmd_valid = 1'b1;
            {cmd_write, cmd_command_parameter, cmd_addr, cmd_len, cmd_data} = {w, p, a, l, d};
            n = 0;
            while (cmd_ready !== 1'b1 && n < 200) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            @(negedge ref_clk);
            cmd_valid = 1'b0;
            {cmd_write, cmd_command_parameter, cmd_addr, cmd_len, cmd_data} = ~{w, p, a, l, d};
            got_ack = 1'bx;
            n = 0;
            while (rsp_valid !== 1'b1 && n < 200) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            if (rsp_valid === 1'b1) begin
                got_ack = rsp_ack;
            end
            got_data = rsp_data;
            got_status = rsp_status;
        end
    endtask
endmodule // cfag_reader_model

// *** verilog/cfag_access_table.v ***
// Access code lookup for one configuration memory byte
`timescale 1ns/1ps
`include "cfag_defines.vh"
module cfag_access_table (
    input wire [7:0] addr, // Byte address in configuration memory
    input wire wr, // High for a write, low for a read
    input wire [1:0] col, // Fuse state column
    output reg [1:0] code, // Access code for this byte
    output reg pw_area // Byte lies in the password sets
);
    // Area, direction and fuse column give the access code
    always @* begin
        code = `CFAG_ACC_FORB;
        pw_area = 1'b0;
        if (addr <= `CFAG_ANTI_HI) begin
            if (addr >= `CFAG_TEST_LO && addr <= `CFAG_TEST_HI)
                code = `CFAG_ACC_OPEN;
            else if (addr >= `CFAG_MAKER_LO)
                code = !wr ? `CFAG_ACC_OPEN :
                       (col <= `CFAG_COL_CRYPT) ? `CFAG_ACC_TPW : `CFAG_ACC_FORB;
            else
                code = !wr ? `CFAG_ACC_OPEN :
                       (col == `CFAG_COL_DEF) ? `CFAG_ACC_TPW : `CFAG_ACC_FORB;
        end else if (addr <= `CFAG_RO_HI) begin
            code = wr ? `CFAG_ACC_FORB : `CFAG_ACC_OPEN;
        end else if (addr <= `CFAG_ACC_HI) begin
            code = !wr ? `CFAG_ACC_OPEN :
                   (col == `CFAG_COL_LOCK) ? `CFAG_ACC_FORB : `CFAG_ACC_TPW;
        end else if (addr <= `CFAG_CRY_HI) begin
            // Session keys sit in the upper half of each 16-byte group
            if (addr[3])
                code = (col == `CFAG_COL_LOCK) ? `CFAG_ACC_FORB : `CFAG_ACC_TPW;
            else
                code = !wr ? `CFAG_ACC_OPEN :
                       (col == `CFAG_COL_LOCK) ? `CFAG_ACC_FORB : `CFAG_ACC_TPW;
        end else if (addr <= `CFAG_SECR_HI) begin
            code = (col == `CFAG_COL_LOCK) ? `CFAG_ACC_FORB : `CFAG_ACC_TPW;
        end else if (addr <= `CFAG_PW_HI) begin
            pw_area = 1'b1;
            // Attempt counters read open at bytes 0 and 4 of a set
            if (!wr && addr[1:0] == 2'h0)
                code = `CFAG_ACC_OPEN;
            else
                code = (col == `CFAG_COL_LOCK) ? `CFAG_ACC_WPW : `CFAG_ACC_TPW;
        end
    end
endmodule // cfag_access_table

// *** verilog/cfag_defines.vh ***
// Constants of the configuration fuse access gate
//
// Contract
// - Four one-time fuses; a programmed fuse never returns to unprogrammed. Reset loads F7 into the fuse byte until the load cycle ANDs in fuse_nv.
// - Factory lock fuse leaves the factory programmed; other three start unprogrammed.
// - Fuses never affect user memory; only configuration memory is gated.
// - Fuse read: read command, parameter 01, address FF, length 00, one byte back.
// - In the fuse byte, 0 means programmed and 1 means unprogrammed.
// - Personalization F0, secret key F1, encryption F2, factory lock F3; F4-F7 reserved.
// - Default state: factory lock 0, others 1; least restrictive column applies.
// - Fuses are programmed only through the fuse-byte-write option of write command.
// - Order is encryption, secret key, personalization; out of order is refused.
// - Encryption fuse write: parameter 01, address 06, length 00, data 00.
// - Secret key fuse write: parameter 01, address 04, length 00, data 00.
// - Personalization fuse write last: parameter 01, address 00, length 00, data 00.
// - Successful fuse write answers acknowledge with fuse byte in status.
// - All three fuses programmed locks configuration: most restrictive column.
// - Access decided by register area, read or write, and fuse state.
// - Anticollision reads open; writes need transport password, forbidden after first stage fuse. 0A-0B writes open; 0C-0F writable until secret key fuse.
// - Cryptography reads open; writes need transport password until personalization fuse. Session key bytes are gated the same way for reads.
// - Transport-password access granted only after transport password validated.
// - Write-password access only to counters and passwords of the validated set.
`ifndef CFAG_DEFINES_VH
`define CFAG_DEFINES_VH
// Command fields
`define CFAG_OPT_FUSE 8'h01
`define CFAG_FUSE_ADDR 8'hff
`define CFAG_LEN_ONE 8'h00
`define CFAG_PROG_DATA 8'h00
`define CFAG_CRYPT_ADDR 8'h06
`define CFAG_KEY_ADDR 8'h04
`define CFAG_PERS_ADDR 8'h00
// Fuse byte bit positions
`define CFAG_BIT_PERS 0
`define CFAG_BIT_KEY 1
`define CFAG_BIT_CRYPT 2
`define CFAG_BIT_FACT 3
// Fuse reset value and reserved upper nibble
`define CFAG_FUSE_RESET 4'h7
`define CFAG_RSVD_BITS 4'hf
// Access codes
`define CFAG_ACC_OPEN 2'h0
`define CFAG_ACC_TPW 2'h1
`define CFAG_ACC_WPW 2'h2
`define CFAG_ACC_FORB 2'h3
// Fuse state columns
`define CFAG_COL_DEF 2'h0
`define CFAG_COL_CRYPT 2'h1
`define CFAG_COL_KEY 2'h2
`define CFAG_COL_LOCK 2'h3
// Configuration memory area bounds
`define CFAG_TEST_LO 8'h0a
`define CFAG_TEST_HI 8'h0b
`define CFAG_MAKER_LO 8'h0c
`define CFAG_ANTI_HI 8'h0f
`define CFAG_RO_HI 8'h17
`define CFAG_ACC_HI 8'h4f
`define CFAG_CRY_HI 8'h8f
`define CFAG_SECR_HI 8'haf
`define CFAG_PW_HI 8'hef
`define CFAG_PW_SET_OFS 3'h2
`endif

// *** verilog/cfag_gate.v ***
// Security fuse holder and configuration access gate
`timescale 1ns/1ps
`include "cfag_defines.vh"
module cfag_gate (
    input wire ref_clk, // System clock, 20 MHz
    input wire rst, // Asynchronous reset, active high
    input wire cmd_valid, // System zone command present
    input wire cmd_write, // High: write command, low: read
    input wire [7:0] cmd_command_parameter, // Command parameter byte
    input wire [7:0] cmd_addr, // Command address byte
    input wire [7:0] cmd_len, // Length, bytes minus one
    input wire [7:0] cmd_data, // First data byte of a write
    output wire cmd_ready, // Gate accepts a command
    input wire tpw_ok, // Transport password validated
    input wire wpw_ok, // A set write password validated
    input wire [2:0] wpw_set, // Index of validated password set
    input wire [3:0] fuse_nv, // Fuse levels read from storage
    output reg fuse_prog, // Request to burn one fuse
    output reg [3:0] fuse_prog_mask, // One-hot fuse to burn
    input wire fuse_prog_done, // Storage finished burning
    output reg cfg_go, // Pass access to config memory
    output reg cfg_go_write, // Direction of passed access
    output reg [7:0] cfg_go_addr, // Start address of passed access
    output reg [7:0] cfg_go_len, // Length of passed access
    output reg rsp_valid, // Response present, one cycle
    output reg rsp_ack, // Acknowledge, else error
    output reg rsp_has_data, // Response carries a data byte
    output reg [7:0] rsp_data, // Data byte of the response
    output reg [7:0] rsp_status, // Status byte of the response
    output wire [7:0] security_fuse_byte, // Current fuse byte
    output wire cfg_locked // Configuration is locked
);
    // Controller states
    localparam ST_LOAD = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_PROG = 2'h2;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [3:0] fuses;
    reg [3:0] next_fuses;
    reg next_fuse_prog;
    reg [3:0] next_fuse_prog_mask;
    reg next_cfg_go;
    reg next_cfg_go_write;
    reg [7:0] next_cfg_go_addr;
    reg [7:0] next_cfg_go_len;
    reg next_rsp_valid;
    reg next_rsp_ack;
    reg next_rsp_has_data;
    reg [7:0] next_rsp_data;
    reg [7:0] next_rsp_status;

    wire [1:0] col;
    wire [8:0] last_sum;
    wire [7:0] last_addr;
    wire [1:0] code_first;
    wire [1:0] code_last;
    wire pw_first;
    wire pw_last;
    wire take;
    wire is_fuse_cmd;
    wire is_fuse_read;
    wire is_fuse_write;
    wire fuse_write_ok;
    wire [3:0] fuse_want;
    wire range_ok;
    wire grant;

    // Fuse byte with reserved upper nibble reading as ones
    assign security_fuse_byte = {`CFAG_RSVD_BITS, fuses};

    // Column from how far personalization has progressed
    function [1:0] fuse_column;
        input [3:0] f;
        begin
            if (!f[`CFAG_BIT_PERS])
                fuse_column = `CFAG_COL_LOCK;
            else if (!f[`CFAG_BIT_KEY])
                fuse_column = `CFAG_COL_KEY;
            else if (!f[`CFAG_BIT_CRYPT])
                fuse_column = `CFAG_COL_CRYPT;
            else
                fuse_column = `CFAG_COL_DEF;
        end
    endfunction

    // Whether one byte's access code is satisfied
    function code_granted;
        input [1:0] code;
        input pw_area;
        input [7:0] addr;
        input tpw;
        input wpw;
        input [2:0] wset;
        reg [2:0] set_idx;
        begin
            set_idx = addr[5:3] + `CFAG_PW_SET_OFS;
            case (code)
                `CFAG_ACC_OPEN: code_granted = 1'b1;
                `CFAG_ACC_TPW: code_granted = tpw;
                `CFAG_ACC_WPW: code_granted = wpw && pw_area && (set_idx == wset);
                default: code_granted = 1'b0;
            endcase
        end
    endfunction

    assign col = fuse_column(fuses);
    assign cfg_locked = (col == `CFAG_COL_LOCK);

    // Last byte of the access; a run past the top is refused
    assign last_sum = {1'b0, cmd_addr} + {1'b0, cmd_len};
    assign last_addr = last_sum[7:0];
    assign range_ok = !last_sum[8];

    // Table lookup for first and last byte of the access
    cfag_access_table u_first (
        .addr(cmd_addr),
        .wr(cmd_write),
        .col(col),
        .code(code_first),
        .pw_area(pw_first)
    );

    cfag_access_table u_last (
        .addr(last_addr),
        .wr(cmd_write),
        .col(col),
        .code(code_last),
        .pw_area(pw_last)
    );

    // Both ends of the access must pass the fuse-state table
    assign grant = range_ok &&
        code_granted(code_first, pw_first, cmd_addr, tpw_ok, wpw_ok, wpw_set) &&
        code_granted(code_last, pw_last, last_addr, tpw_ok, wpw_ok, wpw_set);

    // Command classification
    assign take = cmd_valid && cmd_ready;
    assign is_fuse_cmd = (cmd_command_parameter == `CFAG_OPT_FUSE);
    assign is_fuse_read = is_fuse_cmd && !cmd_write &&
        cmd_addr == `CFAG_FUSE_ADDR && cmd_len == `CFAG_LEN_ONE;
    assign is_fuse_write = is_fuse_cmd && cmd_write &&
        cmd_len == `CFAG_LEN_ONE && cmd_data == `CFAG_PROG_DATA;

    // Fuse named by the write address, one-hot
    assign fuse_want =
        (cmd_addr == `CFAG_CRYPT_ADDR) ? (4'h1 << `CFAG_BIT_CRYPT) :
        (cmd_addr == `CFAG_KEY_ADDR) ? (4'h1 << `CFAG_BIT_KEY) :
        (cmd_addr == `CFAG_PERS_ADDR) ? (4'h1 << `CFAG_BIT_PERS) :
        4'h0;

    // Only the next fuse in sequence may be burnt
    assign fuse_write_ok = is_fuse_write && (
        (col == `CFAG_COL_DEF && cmd_addr == `CFAG_CRYPT_ADDR) ||
        (col == `CFAG_COL_CRYPT && cmd_addr == `CFAG_KEY_ADDR) ||
        (col == `CFAG_COL_KEY && cmd_addr == `CFAG_PERS_ADDR));

    assign cmd_ready = (state == ST_IDLE);

    // Next-state and response logic
    always @* begin
        next_state = state;
        next_fuses = fuses;
        next_fuse_prog = fuse_prog;
        next_fuse_prog_mask = fuse_prog_mask;
        next_cfg_go = 1'b0;
        next_cfg_go_write = cfg_go_write;
        next_cfg_go_addr = cfg_go_addr;
        next_cfg_go_len = cfg_go_len;
        next_rsp_valid = 1'b0;
        next_rsp_ack = rsp_ack;
        next_rsp_has_data = rsp_has_data;
        next_rsp_data = rsp_data;
        next_rsp_status = rsp_status;
        case (state)
            ST_LOAD: begin
                // Stored levels may only add programmed fuses
                next_fuses = fuses & fuse_nv;
                next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (take) begin
                    next_rsp_has_data = 1'b0;
                    next_rsp_data = 8'h00;
                    next_rsp_status = security_fuse_byte;
                    if (is_fuse_read) begin
                        // Single byte answer with fuse levels
                        next_rsp_valid = 1'b1;
                        next_rsp_ack = 1'b1;
                        next_rsp_has_data = 1'b1;
                        next_rsp_data = security_fuse_byte;
                    end else if (fuse_write_ok) begin
                        next_fuse_prog = 1'b1;
                        next_fuse_prog_mask = fuse_want;
                        next_state = ST_PROG;
                    end else if (is_fuse_cmd) begin
                        // Malformed or out-of-order fuse command
                        next_rsp_valid = 1'b1;
                        next_rsp_ack = 1'b0;
                    end else if (grant) begin
                        // Hand the access to config memory
                        next_cfg_go = 1'b1;
                        next_cfg_go_write = cmd_write;
                        next_cfg_go_addr = cmd_addr;
                        next_cfg_go_len = cmd_len;
                        next_rsp_valid = 1'b1;
                        next_rsp_ack = 1'b1;
                    end else begin
                        next_rsp_valid = 1'b1;
                        next_rsp_ack = 1'b0;
                    end
                end
            end
            ST_PROG: begin
                if (fuse_prog_done) begin
                    // Burning only clears bits, never sets them
                    next_fuses = fuses & ~fuse_prog_mask;
                    next_fuse_prog = 1'b0;
                    next_fuse_prog_mask = 4'h0;
                    next_rsp_valid = 1'b1;
                    next_rsp_ack = 1'b1;
                    next_rsp_status = {`CFAG_RSVD_BITS, fuses & ~fuse_prog_mask};
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State and output registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_LOAD;
            fuses <= `CFAG_FUSE_RESET;
            fuse_prog <= 1'b0;
            fuse_prog_mask <= 4'h0;
            cfg_go <= 1'b0;
            cfg_go_write <= 1'b0;
            cfg_go_addr <= 8'h00;
            cfg_go_len <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
            rsp_has_data <= 1'b0;
            rsp_data <= 8'h00;
            rsp_status <= 8'h00;
        end else begin
            state <= next_state;
            fuses <= next_fuses;
            fuse_prog <= next_fuse_prog;
            fuse_prog_mask <= next_fuse_prog_mask;
            cfg_go <= next_cfg_go;
            cfg_go_write <= next_cfg_go_write;
            cfg_go_addr <= next_cfg_go_addr;
            cfg_go_len <= next_cfg_go_len;
            rsp_valid <= next_rsp_valid;
            rsp_ack <= next_rsp_ack;
            rsp_has_data <= next_rsp_has_data;
            rsp_data <= next_rsp_data;
            rsp_status <= next_rsp_status;
        end
    end

    // User zone access never passes through this gate
endmodule // cfag_gate
